// *** rtl/sspc_pkg.sv ***
// Package with register map, field positions, reset values and timing for the sync control block.
package sspc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] SSPC_IDX_HSEL = 6'h12;
  localparam logic [5:0] SSPC_IDX_HWID = 6'h13;
  localparam logic [5:0] SSPC_IDX_VSEL = 6'h14;
  localparam logic [5:0] SSPC_IDX_VWID = 6'h15;
  localparam logic [5:0] SSPC_IDX_LEAD = 6'h16;
  localparam logic [5:0] SSPC_IDX_TRAIL = 6'h17;
  localparam logic [5:0] SSPC_IDX_HOLD = 6'h18;
  localparam logic [5:0] SSPC_IDX_STAT = 6'h3f;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] SSPC_RST_HSEL = 8'h18;
  localparam logic [7:0] SSPC_RST_HWID = 8'h20;
  localparam logic [7:0] SSPC_RST_VSEL = 8'h18;
  localparam logic [7:0] SSPC_RST_VWID = 8'h0a;
  localparam logic [7:0] SSPC_RST_LEAD = 8'h00;
  localparam logic [7:0] SSPC_RST_TRAIL = 8'h00;
  localparam logic [7:0] SSPC_RST_HOLD = 8'h20;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int SSPC_B_SRC_OVR = 7;
  localparam int SSPC_B_SRC_SEL = 6;
  localparam int SSPC_B_POL_OVR = 5;
  localparam int SSPC_B_POL_USR = 4;
  localparam int SSPC_B_OUT_POL = 3;
  localparam int SSPC_B_VS_FILT = 2;
  localparam int SSPC_B_VS_WEN = 1;
  localparam int SSPC_B_HOLD_SRC = 7;
  localparam int SSPC_B_HOLD_POVR = 6;
  localparam int SSPC_B_HOLD_PUSR = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Timing and bus answers.
  localparam int SSPC_CLK_PERIOD_NS = 20;
  localparam int SSPC_ACT_TIMEOUT_NS = 200_000;
  localparam int SSPC_ACT_CYCLES = SSPC_ACT_TIMEOUT_NS / SSPC_CLK_PERIOD_NS;
  localparam logic [1:0] SSPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSPC_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SSPC_HOLD_IDLE = 4'h1,
    SSPC_HOLD_LEAD = 4'h2,
    SSPC_HOLD_VS = 4'h4,
    SSPC_HOLD_TRAIL = 4'h8
  } sspc_hold_t;

endpackage

// *** rtl/sspc_sync_ctrl.sv ***
// Sync source, polarity, width and PLL hold window control with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

module sspc_sync_ctrl
  import sspc_pkg::*;
#(
  parameter int ACT_CYCLES = SSPC_ACT_CYCLES,
  parameter int CNT_W = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic HSYNC_PIN,
  input wire logic GREEN_EMBEDDED_SYNC,
  input wire logic VSYNC_PIN,
  input wire logic SEP_VSYNC,
  input wire logic HOLD_PIN,
  input wire logic PLL_FB_TICK,
  output logic HSYNC_OUT,
  output logic VSYNC_OUT,
  output logic HOLD_OUT,
  output logic PHASE_UPDATE_EN
);

  //////////////////////////////////////////////////////////////////////////////
  // State of the block.
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [1:0][CNT_W-1:0] act_cnt;
    logic [1:0] act;
    logic [2:0][7:0] pol_cnt;
    logic [7:0] r_hsel;
    logic [7:0] r_hwid;
    logic [7:0] r_vsel;
    logic [7:0] r_vwid;
    logic [7:0] r_lead;
    logic [7:0] r_trail;
    logic [7:0] r_hold;
    logic hs_prev;
    logic vs_filt;
    logic vs_prev;
    logic hs_on;
    logic vs_stretch;
    logic [7:0] hcnt;
    logic [7:0] vs_len;
    logic [7:0] trail_cnt;
    logic [11:0] line_cnt;
    logic [11:0] frame_lines;
    sspc_hold_t hold_st;
    logic aw_v;
    logic w_v;
    logic w_ok;
    logic [5:0] aw_idx;
    logic [7:0] w_dat;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic hs_out;
    logic vs_out;
    logic hold_out;
    logic phase_en;
  } sspc_state_t;

  sspc_state_t st_r;
  sspc_state_t st_nxt;

  logic [3:0] chg;
  logic [2:0] raws;
  logic [2:0] det_high;
  logic sel_green;
  logic sel_sep;
  logic hs_pol;
  logic vs_pol;
  logic hold_pol;
  logic hs_n;
  logic vs_n;
  logic hs_rise;
  logic vs_rise;
  logic vs_fall;
  logic vs_eff;
  logic lead_hit;
  logic hold_int;
  logic hold_ext;
  logic hold_sel;
  logic [7:0] status;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    st_nxt = st_r;
    // The hsync, green, vsync and hold pins pass three flops; a level counts once stages two and three agree.
    st_nxt.s1 = {HOLD_PIN, VSYNC_PIN, GREEN_EMBEDDED_SYNC, HSYNC_PIN};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 4; i++) begin
      chg[i] = (st_r.s2[i] == st_r.s3[i]) && (st_r.s3[i] != st_r.filt[i]);
      if (chg[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
    // Activity of the hsync pin and the green sync: any edge within the timeout.
    for (int i = 0; i < 2; i++) begin
      if (chg[i]) begin
        st_nxt.act_cnt[i] = CNT_W'(ACT_CYCLES);
        st_nxt.act[i] = 1'b1;
      end else if (st_r.act_cnt[i] != '0) begin
        st_nxt.act_cnt[i] = st_r.act_cnt[i] - 1'b1;
      end else begin
        st_nxt.act[i] = 1'b0;
      end
    end
    // Hsync source: automatic, or the select bit under override or with both active.
    if (st_r.r_hsel[SSPC_B_SRC_OVR] || (&st_r.act)) begin
      sel_green = st_r.r_hsel[SSPC_B_SRC_SEL];
    end else begin
      sel_green = st_r.act[1] && !st_r.act[0];
    end
    // Vsync source: automatic follows the hsync choice, else the select bit.
    if (st_r.r_vsel[SSPC_B_SRC_OVR]) begin
      sel_sep = st_r.r_vsel[SSPC_B_SRC_SEL];
    end else begin
      sel_sep = sel_green;
    end
    raws[0] = sel_green ? st_r.filt[1] : st_r.filt[0];
    raws[1] = sel_sep ? SEP_VSYNC : st_r.filt[2];
    raws[2] = st_r.filt[3];
    // Polarity detectors: a signal that is mostly high is taken as active low.
    for (int i = 0; i < 3; i++) begin
      if (raws[i] && st_r.pol_cnt[i] != 8'hff) begin
        st_nxt.pol_cnt[i] = st_r.pol_cnt[i] + 8'h01;
      end else if (!raws[i] && st_r.pol_cnt[i] != 8'h00) begin
        st_nxt.pol_cnt[i] = st_r.pol_cnt[i] - 8'h01;
      end
      det_high[i] = !st_r.pol_cnt[i][7];
    end
    hs_pol = st_r.r_hsel[SSPC_B_POL_OVR] ? st_r.r_hsel[SSPC_B_POL_USR] : det_high[0];
    vs_pol = st_r.r_vsel[SSPC_B_POL_OVR] ? st_r.r_vsel[SSPC_B_POL_USR] : det_high[1];
    hold_pol = st_r.r_hold[SSPC_B_HOLD_POVR] ? st_r.r_hold[SSPC_B_HOLD_PUSR] : det_high[2];
    hs_n = raws[0] ~^ hs_pol;
    vs_n = raws[1] ~^ vs_pol;
    hs_rise = hs_n && !st_r.hs_prev;
    st_nxt.hs_prev = hs_n;
    // Vsync filter moves vsync only on hsync leading edges.
    if (!st_r.r_vsel[SSPC_B_VS_FILT] || hs_rise) begin
      st_nxt.vs_filt = vs_n;
    end
    st_nxt.vs_prev = st_r.vs_filt;
    vs_rise = st_r.vs_filt && !st_r.vs_prev;
    vs_fall = !st_r.vs_filt && st_r.vs_prev;
    // Vsync width in hsync periods from the filtered leading edge.
    if (vs_rise && st_r.r_vsel[SSPC_B_VS_WEN] && st_r.r_vwid != 8'h00) begin
      st_nxt.vs_stretch = 1'b1;
      st_nxt.vs_len = st_r.r_vwid;
    end else if (st_r.vs_stretch && st_r.vs_len == 8'h00) begin
      st_nxt.vs_stretch = 1'b0;
    end else if (st_r.vs_stretch && hs_rise) begin
      st_nxt.vs_len = st_r.vs_len - 8'h01;
    end
    vs_eff = st_r.r_vsel[SSPC_B_VS_WEN] ? st_r.vs_stretch : st_r.vs_filt;
    st_nxt.vs_out = vs_eff ~^ st_r.r_vsel[SSPC_B_OUT_POL];
    // Hsync output pulse, started by the feedback tick and timed in pixel clocks.
    if (PLL_FB_TICK && st_r.r_hwid != 8'h00) begin
      st_nxt.hs_on = 1'b1;
      st_nxt.hcnt = st_r.r_hwid;
    end else if (st_r.hs_on) begin
      if (st_r.hcnt == 8'h01) begin
        st_nxt.hs_on = 1'b0;
      end
      st_nxt.hcnt = st_r.hcnt - 8'h01;
    end
    st_nxt.hs_out = st_r.hs_on ~^ st_r.r_hsel[SSPC_B_OUT_POL];
    // Lines per frame, used to place the window ahead of vsync.
    if (vs_rise) begin
      st_nxt.frame_lines = st_r.line_cnt;
      st_nxt.line_cnt = 12'h000;
    end else if (hs_rise && st_r.line_cnt != 12'hfff) begin
      st_nxt.line_cnt = st_r.line_cnt + 12'h001;
    end
    lead_hit = (st_r.r_lead != 8'h00) && (st_r.frame_lines > {4'h0, st_r.r_lead})
      && (({1'b0, st_r.line_cnt} + {5'h00, st_r.r_lead}) >= {1'b0, st_r.frame_lines});
    // Internal hold window sequence.
    case (st_r.hold_st)
      SSPC_HOLD_IDLE: begin
        if (vs_rise) begin
          st_nxt.hold_st = SSPC_HOLD_VS;
        end else if (lead_hit) begin
          st_nxt.hold_st = SSPC_HOLD_LEAD;
        end
      end
      SSPC_HOLD_LEAD: begin
        if (vs_rise) begin
          st_nxt.hold_st = SSPC_HOLD_VS;
        end
      end
      SSPC_HOLD_VS: begin
        if (vs_fall && st_r.r_trail != 8'h00) begin
          st_nxt.hold_st = SSPC_HOLD_TRAIL;
          st_nxt.trail_cnt = st_r.r_trail;
        end else if (vs_fall) begin
          st_nxt.hold_st = SSPC_HOLD_IDLE;
        end
      end
      SSPC_HOLD_TRAIL: begin
        if (vs_rise) begin
          st_nxt.hold_st = SSPC_HOLD_VS;
        end else if (st_r.trail_cnt == 8'h00) begin
          st_nxt.hold_st = SSPC_HOLD_IDLE;
        end else if (hs_rise) begin
          st_nxt.trail_cnt = st_r.trail_cnt - 8'h01;
        end
      end
      default: begin
        st_nxt.hold_st = SSPC_HOLD_IDLE;
      end
    endcase
    hold_int = st_r.hold_st != SSPC_HOLD_IDLE;
    hold_ext = raws[2] ~^ hold_pol;
    hold_sel = st_r.r_hold[SSPC_B_HOLD_SRC] ? hold_ext : hold_int;
    st_nxt.hold_out = hold_sel;
    st_nxt.phase_en = !hold_sel;
    status = {hold_pol, st_r.hold_out, det_high[1], det_high[0], sel_sep, sel_green, st_r.act};
    // Write channel: address and data are taken in either order.
    if (S_AXI_AWVALID && st_r.awready) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_idx = S_AXI_AWADDR[7:2];
    end
    if (S_AXI_WVALID && st_r.wready) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_dat = S_AXI_WDATA[7:0];
      st_nxt.w_ok = S_AXI_WSTRB[0];
    end
    if (st_r.aw_v && st_r.w_v && !st_r.bvalid) begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = SSPC_RESP_OKAY;
      case (st_r.aw_idx)
        SSPC_IDX_HSEL: if (st_r.w_ok) st_nxt.r_hsel = st_r.w_dat;
        SSPC_IDX_HWID: if (st_r.w_ok) st_nxt.r_hwid = st_r.w_dat;
        SSPC_IDX_VSEL: if (st_r.w_ok) st_nxt.r_vsel = st_r.w_dat;
        SSPC_IDX_VWID: if (st_r.w_ok) st_nxt.r_vwid = st_r.w_dat;
        SSPC_IDX_LEAD: if (st_r.w_ok) st_nxt.r_lead = st_r.w_dat;
        SSPC_IDX_TRAIL: if (st_r.w_ok) st_nxt.r_trail = st_r.w_dat;
        SSPC_IDX_HOLD: if (st_r.w_ok) st_nxt.r_hold = st_r.w_dat;
        default: st_nxt.bresp = SSPC_RESP_SLVERR;
      endcase
    end else if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_v && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_v && !st_nxt.bvalid;
    // Read channel: data is captured in the cycle the address is taken.
    if (S_AXI_ARVALID && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = SSPC_RESP_OKAY;
      case (S_AXI_ARADDR[7:2])
        SSPC_IDX_HSEL: st_nxt.rdata = st_r.r_hsel;
        SSPC_IDX_HWID: st_nxt.rdata = st_r.r_hwid;
        SSPC_IDX_VSEL: st_nxt.rdata = st_r.r_vsel;
        SSPC_IDX_VWID: st_nxt.rdata = st_r.r_vwid;
        SSPC_IDX_LEAD: st_nxt.rdata = st_r.r_lead;
        SSPC_IDX_TRAIL: st_nxt.rdata = st_r.r_trail;
        SSPC_IDX_HOLD: st_nxt.rdata = st_r.r_hold;
        SSPC_IDX_STAT: st_nxt.rdata = status;
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.rresp = SSPC_RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '0;
      st_r.r_hsel <= SSPC_RST_HSEL;
      st_r.r_hwid <= SSPC_RST_HWID;
      st_r.r_vsel <= SSPC_RST_VSEL;
      st_r.r_vwid <= SSPC_RST_VWID;
      st_r.r_lead <= SSPC_RST_LEAD;
      st_r.r_trail <= SSPC_RST_TRAIL;
      st_r.r_hold <= SSPC_RST_HOLD;
      st_r.hold_st <= SSPC_HOLD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign S_AXI_AWREADY = st_r.awready;
  assign S_AXI_WREADY = st_r.wready;
  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP = st_r.bresp;
  assign S_AXI_ARREADY = st_r.arready;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RRESP = st_r.rresp;
  assign S_AXI_RDATA = {24'h00_0000, st_r.rdata};
  assign HSYNC_OUT = st_r.hs_out;
  assign VSYNC_OUT = st_r.vs_out;
  assign HOLD_OUT = st_r.hold_out;
  assign PHASE_UPDATE_EN = st_r.phase_en;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  default clocking sspc_cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  AST_HSRC_USER: assert property (
    st_r.r_hsel[SSPC_B_SRC_OVR] |-> sel_green == st_r.r_hsel[SSPC_B_SRC_SEL])
    else $error("Hsync source ignores the select bit under override.");
  AST_HSRC_AUTO: assert property (
    !st_r.r_hsel[SSPC_B_SRC_OVR] && st_r.act == 2'b10 |-> sel_green)
    else $error("Automatic hsync source misses the only active input.");
  AST_HPOL: assert property (
    st_r.r_hsel[SSPC_B_POL_OVR] |-> hs_pol == st_r.r_hsel[SSPC_B_POL_USR])
    else $error("Hsync input polarity ignores the user bit.");
  AST_HS_OUT: assert property (
    1'b1 |=> HSYNC_OUT == ($past(st_r.hs_on) ~^ $past(st_r.r_hsel[SSPC_B_OUT_POL])))
    else $error("Hsync output polarity is wrong.");
  AST_HS_WIDTH: assert property (
    PLL_FB_TICK && st_r.r_hwid == 8'h02 ##1 !PLL_FB_TICK [*2] |-> st_r.hs_on ##1 !st_r.hs_on)
    else $error("Hsync pulse width differs from the width register.");
  AST_VSRC: assert property (
    st_r.r_vsel[SSPC_B_SRC_OVR] |-> sel_sep == st_r.r_vsel[SSPC_B_SRC_SEL])
    else $error("Vsync source ignores the select bit under override.");
  AST_VPOL: assert property (
    st_r.r_vsel[SSPC_B_POL_OVR] |-> vs_pol == st_r.r_vsel[SSPC_B_POL_USR])
    else $error("Vsync input polarity ignores the user bit.");
  AST_VS_OUT: assert property (
    1'b1 |=> VSYNC_OUT == ($past(vs_eff) ~^ $past(st_r.r_vsel[SSPC_B_OUT_POL])))
    else $error("Vsync output polarity is wrong.");
  AST_VS_FILT: assert property (
    st_r.r_vsel[SSPC_B_VS_FILT] && !hs_rise |=> $stable(st_r.vs_filt))
    else $error("Filtered vsync moved away from an hsync edge.");
  AST_VS_PASS: assert property (
    !st_r.r_vsel[SSPC_B_VS_FILT] |=> st_r.vs_filt == $past(vs_n))
    else $error("Unfiltered vsync does not follow the input.");
  AST_VS_WIDTH: assert property (
    vs_rise && st_r.r_vsel[SSPC_B_VS_WEN] && st_r.r_vwid != 8'h00 |=>
      st_r.vs_stretch && st_r.vs_len == $past(st_r.r_vwid))
    else $error("Vsync width does not load from the width register.");
  AST_LEAD: assert property (
    st_r.hold_st == SSPC_HOLD_IDLE && lead_hit && !vs_rise |=> st_r.hold_st == SSPC_HOLD_LEAD)
    else $error("Hold window does not open ahead of vsync.");
  AST_TRAIL: assert property (
    st_r.hold_st == SSPC_HOLD_VS && vs_fall && st_r.r_trail != 8'h00 |=>
      st_r.hold_st == SSPC_HOLD_TRAIL && st_r.trail_cnt == $past(st_r.r_trail))
    else $error("Hold window does not extend after vsync.");
  AST_HOLD_INT: assert property (
    !st_r.r_hold[SSPC_B_HOLD_SRC] |=> HOLD_OUT == ($past(st_r.hold_st) != SSPC_HOLD_IDLE))
    else $error("Internal hold window does not reach the output.");
  AST_HOLD_EXT: assert property (
    st_r.r_hold[SSPC_B_HOLD_SRC] && st_r.r_hold[SSPC_B_HOLD_POVR] |=>
      HOLD_OUT == ($past(st_r.r_hold[SSPC_B_HOLD_PUSR]) ~^ $past(st_r.filt[3])))
    else $error("External hold polarity is wrong.");
  AST_FREEZE: assert property (
    HOLD_OUT |-> !PHASE_UPDATE_EN)
    else $error("Phase updates continue during hold.");

  COV_HS_PULSE: cover property ($rose(st_r.hs_on));
  COV_TRAIL: cover property (st_r.hold_st == SSPC_HOLD_TRAIL);
  COV_STRETCH: cover property ($rose(st_r.vs_stretch));
  COV_WRITE: cover property (S_AXI_BVALID && S_AXI_BREADY);

endmodule // sspc_sync_ctrl

`default_nettype wire

// *** verif/sspc_sync_source.sv ***
// Model of the incoming video source that feeds sync pins and the feedback tick.
`timescale 1ns/1ps
`default_nettype none

module sspc_sync_source #(
  parameter int LINE = 40,
  parameter int LINES = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HPOL,
  input wire logic HMUTE,
  output logic HSYNC,
  output logic GREEN,
  output logic VSYNC,
  output logic SEP_VS,
  output logic FB_TICK
);
  int px;
  int ln;
  logic hact;

  //////////////////////////////////////////////////////////////////////////////
  // Pixel and line counters pace the frame.
  always_ff @(posedge CLK) begin
    if (RST) begin
      px <= 0;
      ln <= 0;
    end else begin
      px <= (px == LINE - 1) ? 0 : px + 1;
      if (px == LINE - 1) begin
        ln <= (ln == LINES - 1) ? 0 : ln + 1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync pulses of four pixels per line and two lines per frame.
  assign hact = (px < 4);
  assign GREEN = HPOL ? hact : ~hact;
  assign HSYNC = HMUTE ? 1'b0 : GREEN;
  assign VSYNC = (ln >= 4) && (ln < 6);
  assign SEP_VS = VSYNC;
  assign FB_TICK = (px == 1);
endmodule // sspc_sync_source

`default_nettype wire

// *** verif/sspc_sync_ctrl_bench.sv ***
// Testbench for the sync control block driven over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module sspc_sync_ctrl_bench;
  import sspc_pkg::*;
  localparam int LINE = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, hpol = 1'b1, hold_pin = 1'b0;
  logic hmute = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, hs_pin, green, vs_pin, sep_vs, fb_tick;
  logic hs_out, vs_out, hold_out, ph_en, probe;
  logic [1:0] bresp, rresp;
  logic [1:0] psel = 2'h0;
  logic [31:0] rdata, rd;
  int bad_count = 0, compares = 0, cyc = 0, n;
  logic [5:0] idx [7] = '{SSPC_IDX_HSEL, SSPC_IDX_HWID, SSPC_IDX_VSEL, SSPC_IDX_VWID, SSPC_IDX_LEAD,
                          SSPC_IDX_TRAIL, SSPC_IDX_HOLD};
  logic [7:0] rstv [7] = '{8'h18, 8'h20, 8'h18, 8'h0a, 8'h00, 8'h00, 8'h20};
  logic [7:0] vcfg [3] = '{8'hbe, 8'hb6, 8'hbc};
  int vexp [3] = '{3, 3, 2};
  int lead [3] = '{0, 0, 1};
  int trail [3] = '{0, 2, 2};

  initial forever #10 clk = ~clk;
  assign probe = (psel == 2'h0) ? hs_out : ((psel == 2'h1) ? vs_out : hold_out);

  sspc_sync_ctrl #(.ACT_CYCLES(50)) i_sspc_sync_ctrl (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .HSYNC_PIN(hs_pin), .GREEN_EMBEDDED_SYNC(green), .VSYNC_PIN(vs_pin), .SEP_VSYNC(sep_vs),
    .HOLD_PIN(hold_pin), .PLL_FB_TICK(fb_tick), .HSYNC_OUT(hs_out), .VSYNC_OUT(vs_out),
    .HOLD_OUT(hold_out), .PHASE_UPDATE_EN(ph_en));

  sspc_sync_source #(.LINE(LINE), .LINES(12)) i_sspc_sync_source (.CLK(clk), .RST(rst), .HPOL(hpol),
    .HMUTE(hmute), .HSYNC(hs_pin), .GREEN(green), .VSYNC(vs_pin), .SEP_VS(sep_vs), .FB_TICK(fb_tick));

  //////////////////////////////////////////////////////////////////////////////
  // Compare, bus and measurement tasks.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      if (b) chk(32'(bresp), 32'(er));
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask

  task rdr(input logic [5:0] i, input logic [1:0] er, output logic [31:0] d);
    logic a, r;
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      a = arvalid & arready;
      r = rvalid;
      d = rdata;
      if (r) chk(32'(rresp), 32'(er));
      @(posedge clk);
      if (a) arvalid <= 1'b0;
    end while (!r);
    rready <= 1'b0;
  endtask

  task pulse(input logic [1:0] s, input logic lvl, output int cnt);
    psel = s;
    cnt = 0;
    @(negedge clk);
    while (probe === lvl) @(negedge clk);
    while (probe !== lvl) @(negedge clk);
    while (probe === lvl) begin
      cnt++;
      @(negedge clk);
    end
  endtask

  task results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      results;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      rdr(idx[k], SSPC_RESP_OKAY, rd);
      chk(rd, 32'(rstv[k]));
    end
    wr(SSPC_IDX_LEAD, 8'h5a, SSPC_RESP_OKAY);
    rdr(SSPC_IDX_LEAD, SSPC_RESP_OKAY, rd);
    chk(rd, 32'h0000_005a);
    wr(6'h20, 8'h11, SSPC_RESP_SLVERR);
    rdr(6'h20, SSPC_RESP_SLVERR, rd);
    chk(rd, 32'h0000_0000);
    wr(SSPC_IDX_STAT, 8'hff, SSPC_RESP_SLVERR);
    wr(SSPC_IDX_LEAD, 8'h00, SSPC_RESP_OKAY);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      wr(SSPC_IDX_HWID, k[0] ? 8'h07 : 8'h02, SSPC_RESP_OKAY);
      wr(SSPC_IDX_HSEL, k[1] ? 8'h18 : 8'h10, SSPC_RESP_OKAY);
      pulse(2'h0, k[1], n);
      chk(32'(n), k[0] ? 32'h0000_0007 : 32'h0000_0002);
    end
    $display("test hsync output done");
    for (int k = 0; k < 2; k++) begin
      wr(SSPC_IDX_HSEL, k[0] ? 8'hd8 : 8'h98, SSPC_RESP_OKAY);
      wr(SSPC_IDX_VSEL, k[0] ? 8'hd8 : 8'h98, SSPC_RESP_OKAY);
      rdr(SSPC_IDX_STAT, SSPC_RESP_OKAY, rd);
      chk(32'(rd[3:2]), k[0] ? 32'h0000_0003 : 32'h0000_0000);
    end
    for (int k = 0; k < 2; k++) begin
      hpol <= k[0];
      repeat (3000) @(posedge clk);
      rdr(SSPC_IDX_STAT, SSPC_RESP_OKAY, rd);
      chk(32'(rd[4]), 32'(k[0]));
    end
    wr(SSPC_IDX_HSEL, 8'h18, SSPC_RESP_OKAY);
    hmute <= 1'b1;
    repeat (200) @(posedge clk);
    rdr(SSPC_IDX_STAT, SSPC_RESP_OKAY, rd);
    chk(32'(rd[2:0]), 32'h0000_0006);
    hmute <= 1'b0;
    $display("test source and detect done");
    wr(SSPC_IDX_VWID, 8'h03, SSPC_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      wr(SSPC_IDX_VSEL, vcfg[k], SSPC_RESP_OKAY);
      pulse(2'h1, vcfg[k][3], n);
      pulse(2'h1, vcfg[k][3], n);
      chk(32'(n), 32'(vexp[k] * LINE));
    end
    $display("test vsync output done");
    wr(SSPC_IDX_VSEL, 8'hbc, SSPC_RESP_OKAY);
    wr(SSPC_IDX_HOLD, 8'h20, SSPC_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      wr(SSPC_IDX_LEAD, 8'(lead[k]), SSPC_RESP_OKAY);
      wr(SSPC_IDX_TRAIL, 8'(trail[k]), SSPC_RESP_OKAY);
      pulse(2'h2, 1'b1, n);
      pulse(2'h2, 1'b1, n);
      chk(32'(n), 32'((2 + lead[k] + trail[k]) * LINE));
    end
    for (int k = 0; k < 4; k++) begin
      wr(SSPC_IDX_HOLD, k[1] ? 8'he0 : 8'hc0, SSPC_RESP_OKAY);
      hold_pin <= k[0];
      repeat (8) @(posedge clk);
      chk(32'({hold_out, ph_en}), (k[0] == k[1]) ? 32'h0000_0002 : 32'h0000_0001);
    end
    $display("test hold window done");
    results;
  end
endmodule // sspc_sync_ctrl_bench

`default_nettype wire
